//--- shared/iwd_defines.svh
// Field positions, widths and fixed codes of the instruction word decoder
`ifndef IWD_DEFINES_SVH
`define IWD_DEFINES_SVH
// Word sizes
`define IWD_WORD_W 24
`define IWD_PAIR_W 48
`define IWD_OPC_W 8
// Opcode field (top byte)
`define IWD_OPC_MSB 23
`define IWD_OPC_LSB 16
// Class select inside the opcode
`define IWD_CLS_MSB 7
`define IWD_CLS_LSB 5
// Lone second word: opcode all zero
`define IWD_OPC_NOP 8'h00
// Double-word opcodes (plain defaults)
`define IWD_DW_OPC0 8'h02
`define IWD_DW_OPC1 8'h04
`define IWD_DW_OPC2 8'h06
// Register-form operand fields
`define IWD_BASE_LSB 15
`define IWD_BYTE_BIT 14
`define IWD_DMODE_LSB 11
`define IWD_DST_LSB 7
`define IWD_SMODE_LSB 4
`define IWD_SRC_LSB 0
// File-register form
`define IWD_DSEL_BIT 13
`define IWD_FADDR_LSB 0
// Bit form
`define IWD_BPOS_LSB 0
`define IWD_BIND_BIT 4
`define IWD_BFILE_BIT 5
// Literal form
`define IWD_LIT_LSB 4
`define IWD_LDST_BIT 14
// MAC form
`define IWD_ACC_BIT 15
`define IWD_MUL_LSB 12
`define IWD_XPF_LSB 10
`define IWD_XPD_LSB 8
`define IWD_YPF_LSB 6
`define IWD_YPD_LSB 4
`define IWD_AWB_LSB 2
// Other DSP form
`define IWD_SHREG_BIT 14
`define IWD_SHLIT_LSB 4
// Control form
`define IWD_PLOW_LSB 0
`define IWD_PHIGH_LSB 0
`define IWD_TMODE_LSB 0
`endif

//--- shared/iwd_pkg.sv
// Types shared by the instruction word decoder files
package iwd_pkg;
  // Instruction groups, picked by the top opcode bits
  typedef enum logic [2:0] {
    IWD_CLS_CTRL = 3'b000,
    IWD_CLS_DEFAULT_WORKING_REG = 3'b001,
    IWD_CLS_FILE = 3'b010,
    IWD_CLS_BIT = 3'b011,
    IWD_CLS_LARI = 3'b100,
    IWD_CLS_LMOV = 3'b101,
    IWD_CLS_MAC = 3'b110,
    IWD_CLS_DSP = 3'b111
  } iwd_class_t;
  // Sequencer states
  typedef enum logic [0:0] {
    IWD_ST_FIRST = 1'b0,
    IWD_ST_SECOND = 1'b1
  } iwd_state_t;
  // Decoded operation handed to the datapath
  typedef struct packed {
    logic [7:0] opcode;
    iwd_class_t iclass;
    logic is_double;
    logic is_nop;
    logic byte_op;
    logic [3:0] base_source_reg;
    logic [3:0] second_source_reg;
    logic [2:0] src_mode;
    logic [3:0] result_dest_reg;
    logic [2:0] dst_mode;
    logic [12:0] file_addr;
    logic to_default_working_reg;
    logic [3:0] bit_pos;
    logic bit_indirect;
    logic bit_in_file;
    logic [9:0] literal;
    logic lit_has_dest;
    logic acc_b;
    logic [2:0] mul_sel;
    logic [1:0] x_pf_op;
    logic [1:0] x_pf_dst;
    logic [1:0] y_pf_op;
    logic [1:0] y_pf_dst;
    logic [1:0] acc_wb;
    logic shift_from_reg;
    logic [3:0] shift_lit;
    logic [3:0] shift_count_reg;
    logic [22:0] prog_addr;
    logic [3:0] tbl_mode;
  } iwd_dec_t;
endpackage : iwd_pkg

//--- hdl/iwd_word_hold.sv
// Holding store for the first word of a double-word instruction
`timescale 1ns/1ps
module iwd_word_hold
  import iwd_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);
  // ==========================================
  // Storage
  // ==========================================
  // Held word; read data comes straight from this flop
  logic [WIDTH-1:0] store_r;

  // Capture on load, keep otherwise
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      store_r <= '0;
    end else if (load) begin
      store_r <= wr_data;
    end
  end

  assign rd_data = store_r;
endmodule : iwd_word_hold

//--- hdl/iwd_decoder.sv
// Instruction word decoder: splits program words into opcode and operand fields
//
// Functional notes
// - One 24-bit word is one instruction, except the three double-word opcodes.
// - Split word into 8-bit opcode and operands.
// - Exactly three opcodes span two words.
// - Double-word instruction decoded from the first word plus second word bits 6:0.
// - Second word top eight bits are zero.
// - Lone second word executes as no-operation.
// - File ops: address, result to file/default.
// - Register ops decode base, source, destination.
// - Bit ops: register plus literal/indirect bit.
// - Literal ops: base, literal, optional destination.
// - MAC names accumulator, multipliers, write-back.
// - MAC carries X and Y prefetch fields.
// - Other DSP: accumulator plus modifiable operand.
// - DSP shift amount from register or literal.
// - Control carries address; table mode field.
`timescale 1ns/1ps
`include "iwd_defines.svh"
module iwd_decoder
  import iwd_pkg::*;
#(
  parameter logic [7:0] DW_OPC0 = `IWD_DW_OPC0,
  parameter logic [7:0] DW_OPC1 = `IWD_DW_OPC1,
  parameter logic [7:0] DW_OPC2 = `IWD_DW_OPC2
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic fetch_valid,
  input wire logic [`IWD_WORD_W-1:0] fetch_word,
  input wire logic fetch_flush,
  output logic dec_valid_r,
  output iwd_dec_t dec_out_r,
  output logic dw_pending_r,
  output logic dw_fault_r
);
  // ==========================================
  // Helper functions
  // ==========================================
  // Opcode lies in the top byte of any word
  // opcode field split
  function automatic logic [7:0] opc_of(input logic [`IWD_WORD_W-1:0] w);
    opc_of = w[`IWD_OPC_MSB:`IWD_OPC_LSB];
  endfunction : opc_of

  // True for the three double-word opcodes
  function automatic logic is_dw_opc(input logic [7:0] op);
    is_dw_opc = (op == DW_OPC0) || (op == DW_OPC1) || (op == DW_OPC2);
  endfunction : is_dw_opc

  // Field decode of a first word plus an optional second word
  function automatic iwd_dec_t decode(input logic [`IWD_WORD_W-1:0] w,
                                      input logic [`IWD_WORD_W-1:0] w2,
                                      input logic dbl);
    iwd_dec_t d;
    d = '0;
    d.opcode = opc_of(w);
    d.iclass = iwd_class_t'(d.opcode[`IWD_CLS_MSB:`IWD_CLS_LSB]);
    d.is_double = dbl;
    d.is_nop = (d.opcode == `IWD_OPC_NOP);
    d.byte_op = w[`IWD_BYTE_BIT];
    d.base_source_reg = w[`IWD_BASE_LSB +: 4];
    d.second_source_reg = w[`IWD_SRC_LSB +: 4];
    d.src_mode = w[`IWD_SMODE_LSB +: 3];
    d.result_dest_reg = w[`IWD_DST_LSB +: 4];
    d.dst_mode = w[`IWD_DMODE_LSB +: 3];
    unique case (d.iclass)
      // file address, result to file or default
      IWD_CLS_FILE: begin
        d.file_addr = w[`IWD_FADDR_LSB +: 13];
        d.to_default_working_reg = ~w[`IWD_DSEL_BIT];
      end
      // bit number literal or from base source
      IWD_CLS_BIT: begin
        d.bit_pos = w[`IWD_BPOS_LSB +: 4];
        d.bit_indirect = w[`IWD_BIND_BIT];
        d.bit_in_file = w[`IWD_BFILE_BIT];
        d.file_addr = w[`IWD_FADDR_LSB +: 13];
      end
      // base plus literal, destination only if flagged
      IWD_CLS_LARI: begin
        d.literal = w[`IWD_LIT_LSB +: 10];
        d.lit_has_dest = w[`IWD_LDST_BIT];
      end
      // Literal move: value into register or file
      IWD_CLS_LMOV: begin
        d.literal = w[`IWD_LIT_LSB +: 10];
        d.file_addr = w[`IWD_FADDR_LSB +: 13];
      end
      IWD_CLS_MAC: begin
        d.acc_b = w[`IWD_ACC_BIT];
        d.mul_sel = w[`IWD_MUL_LSB +: 3];
        d.acc_wb = w[`IWD_AWB_LSB +: 2];
        // separate X and Y prefetch fields
        d.x_pf_op = w[`IWD_XPF_LSB +: 2];
        d.x_pf_dst = w[`IWD_XPD_LSB +: 2];
        d.y_pf_op = w[`IWD_YPF_LSB +: 2];
        d.y_pf_dst = w[`IWD_YPD_LSB +: 2];
      end
      IWD_CLS_DSP: begin
        d.acc_b = w[`IWD_ACC_BIT];
        // shift count from register or literal
        d.shift_from_reg = w[`IWD_SHREG_BIT];
        d.shift_lit = w[`IWD_SHLIT_LSB +: 4];
        d.shift_count_reg = w[`IWD_SRC_LSB +: 4];
      end
      IWD_CLS_CTRL: begin
        d.tbl_mode = w[`IWD_TMODE_LSB +: 4];
        // high address bits come from the second word
        d.prog_addr = dbl ? {w2[`IWD_PHIGH_LSB +: 7], w[`IWD_PLOW_LSB +: 16]}
                          : {7'h00, w[`IWD_PLOW_LSB +: 16]};
      end
      IWD_CLS_DEFAULT_WORKING_REG: begin
        d.lit_has_dest = 1'b0;
      end
    endcase
    decode = d;
  endfunction : decode

  // ==========================================
  // Sequencer
  // ==========================================
  // Current state
  iwd_state_t state_r;
  // Held first word
  logic [`IWD_WORD_W-1:0] held_word;
  // Fetched word has a double-word opcode
  logic start_dw;
  // Load strobe into the holding store
  logic hold_load;

  assign start_dw = fetch_valid && (state_r == IWD_ST_FIRST) && is_dw_opc(opc_of(fetch_word));
  // first word parked until its partner
  assign hold_load = start_dw;

  // Holding register kept apart so the pair path stays narrow
  iwd_word_hold #(
    .WIDTH(`IWD_WORD_W)
  ) u_hold (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(hold_load),
    .wr_data(fetch_word),
    .rd_data(held_word)
  );

  // State update; flush drops a half-gathered pair
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= IWD_ST_FIRST;
    end else if (fetch_flush) begin
      state_r <= IWD_ST_FIRST;
    end else begin
      unique case (state_r)
        IWD_ST_FIRST: begin
          if (start_dw) begin
            state_r <= IWD_ST_SECOND;
          end
        end
        IWD_ST_SECOND: begin
          if (fetch_valid) begin
            state_r <= IWD_ST_FIRST;
          end
        end
      endcase
    end
  end

  // Pending flag mirrors the wait state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dw_pending_r <= 1'b0;
    end else if (fetch_flush) begin
      dw_pending_r <= 1'b0;
    end else if (start_dw) begin
      dw_pending_r <= 1'b1;
    end else if (fetch_valid) begin
      dw_pending_r <= 1'b0;
    end
  end

  // ==========================================
  // Decode output
  // ==========================================
  // One decoded op per single word or per completed pair
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dec_valid_r <= 1'b0;
      dec_out_r <= '0;
    end else if (fetch_flush || !fetch_valid || start_dw) begin
      // nothing issued while the first word waits
      dec_valid_r <= 1'b0;
    end else if (state_r == IWD_ST_SECOND) begin
      dec_valid_r <= 1'b1;
      dec_out_r <= decode(held_word, fetch_word, 1'b1);
    end else begin
      // a lone word is a full instruction
      // zero top byte decodes as no-operation
      dec_valid_r <= 1'b1;
      dec_out_r <= decode(fetch_word, '0, 1'b0);
    end
  end

  // Second word with a nonzero top byte; pair still issued
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dw_fault_r <= 1'b0;
    end else begin
      // upper byte of a second word must be zero
      dw_fault_r <= fetch_valid && !fetch_flush && (state_r == IWD_ST_SECOND) &&
                    (opc_of(fetch_word) != `IWD_OPC_NOP);
    end
  end

  // ==========================================
  // Checks
  // ==========================================
  // Single word yields its own top byte as opcode next cycle
  a_single_opcode:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fetch_valid && !fetch_flush && state_r == IWD_ST_FIRST && !start_dw)
      |=> (dec_valid_r && dec_out_r.opcode == $past(fetch_word[`IWD_OPC_MSB:`IWD_OPC_LSB])))
    else $error("single word opcode not issued");

  // Single word is decoded alone, not as a pair
  a_single_word:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fetch_valid && !fetch_flush && state_r == IWD_ST_FIRST && !start_dw)
      |=> !dec_out_r.is_double)
    else $error("single word marked double");

  // Double-word opcode suppresses output and waits
  a_dw_wait:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (start_dw && !fetch_flush) |=> (!dec_valid_r && dw_pending_r && state_r == IWD_ST_SECOND))
    else $error("double word start not held");

  // Pair completes as one op carrying the first opcode
  a_pair_issue:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (start_dw && !fetch_flush) ##1 (fetch_valid && !fetch_flush)
      |=> (dec_valid_r && dec_out_r.is_double && dec_out_r.opcode == $past(held_word[23:16])))
    else $error("pair not issued as one op");

  // Control pair takes high address bits from second word
  a_pair_addr:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fetch_valid && !fetch_flush && state_r == IWD_ST_SECOND)
      |=> (dec_out_r.prog_addr[22:16] == $past(fetch_word[6:0]) ||
           dec_out_r.iclass != IWD_CLS_CTRL))
    else $error("pair address not combined");

  // Lone zero-top word decodes as no-operation
  a_lone_nop:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fetch_valid && !fetch_flush && state_r == IWD_ST_FIRST && fetch_word[23:16] == 8'h00)
      |=> (dec_valid_r && dec_out_r.is_nop))
    else $error("lone second word not a nop");

  // Nonzero second-word top byte raises the fault flag
  a_second_zero:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fetch_valid && !fetch_flush && state_r == IWD_ST_SECOND && fetch_word[23:16] != 8'h00)
      |=> dw_fault_r)
    else $error("second word fault missed");

  // File op sends result to default register when select bit clear
  a_file_dest:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fetch_valid && !fetch_flush && state_r == IWD_ST_FIRST && fetch_word[23:21] == 3'b010)
      |=> (dec_out_r.to_default_working_reg == !$past(fetch_word[13]) &&
           dec_out_r.file_addr == $past(fetch_word[12:0])))
    else $error("file destination wrong");

  // MAC accumulator choice follows its bit
  a_mac_acc:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fetch_valid && !fetch_flush && state_r == IWD_ST_FIRST && fetch_word[23:21] == 3'b110)
      |=> (dec_out_r.acc_b == $past(fetch_word[15]) && dec_out_r.x_pf_op == $past(fetch_word[11:10])))
    else $error("mac fields wrong");

  // Flush abandons a waiting pair within one cycle
  a_flush_drop:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      fetch_flush |=> (!dw_pending_r && !dec_valid_r))
    else $error("flush did not clear pair");

  // Other DSP op keeps accumulator and shift source bits
  a_dsp_shift:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fetch_valid && !fetch_flush && state_r == IWD_ST_FIRST && fetch_word[23:21] == 3'b111)
      |=> (dec_out_r.acc_b == $past(fetch_word[15]) && dec_out_r.shift_from_reg == $past(fetch_word[14])))
    else $error("dsp shift fields wrong");
endmodule : iwd_decoder

//--- tb/iwd_fetch_model.sv
// Fetch path model that hands program words to the decoder
`timescale 1ns/1ps
module iwd_fetch_model (
  core_clk,
  fetch_valid,
  fetch_word
);
  input wire logic core_clk;
  output logic fetch_valid;
  output logic [23:0] fetch_word;
  // Last word shown, so an idle bus can show its inverse
  logic [23:0] last_r;
  // =====================================
  // Drivers
  initial begin
    fetch_valid = 1'b0;
    fetch_word = 24'h000000;
    last_r = 24'h000000;
  end
  // One word for one cycle, changed off the sampling edge
  task automatic put(input logic [23:0] w);
    @(negedge core_clk);
    fetch_valid = 1'b1;
    fetch_word = w;
    last_r = w;
  endtask : put
  // Released bus shows junk, so a stale word cannot pass by luck
  task automatic idle();
    @(negedge core_clk);
    fetch_valid = 1'b0;
    fetch_word = ~last_r;
  endtask : idle
endmodule : iwd_fetch_model

//--- tb/iwd_decoder_tb_top.sv
// Self-checking bench for the instruction word decoder
`timescale 1ns/1ps
module iwd_decoder_tb_top;
  import iwd_pkg::*;
  logic core_clk;
  logic sys_rst;
  logic fetch_flush;
  logic fetch_valid;
  logic [23:0] fetch_word;
  logic dec_valid;
  iwd_dec_t d;
  logic dw_pending;
  logic dw_fault;
  logic [23:0] w;
  int n_fail;
  int checked;
  // =====================================
  // Clock and instances
  always #5 core_clk = ~core_clk;
  iwd_decoder iwd_decoder_i (.core_clk(core_clk), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_flush(fetch_flush), .dec_valid_r(dec_valid), .dec_out_r(d),
    .dw_pending_r(dw_pending), .dw_fault_r(dw_fault));
  iwd_fetch_model iwd_fetch_model_i (.core_clk(core_clk), .fetch_valid(fetch_valid), .fetch_word(fetch_word));
  // =====================================
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  // Single word in, decoded one cycle later
  task automatic one(input logic [23:0] x);
    w = x;
    iwd_fetch_model_i.put(w);
    iwd_fetch_model_i.idle();
    chk(32'(dec_valid), 32'h1);
    chk(32'(d.opcode), 32'(w[23:16]));
    chk(32'(d.iclass), 32'(w[23:21]));
    chk(32'(d.is_double), 32'h0);
    chk(32'(d.is_nop), 32'(w[23:16] == 8'h00));
  endtask : one
  // =====================================
  // Scenarios
  // Every operand form once except literal move; 0x03 sits between two pair codes
  task automatic t_forms();
    one(24'h2a5b3c);
    chk(32'({d.base_source_reg, d.byte_op}), 32'({w[18:15], w[14]}));
    chk(32'({d.dst_mode, d.result_dest_reg}), 32'(w[13:7]));
    chk(32'({d.src_mode, d.second_source_reg}), 32'(w[6:0]));
    one(24'h4a1abc);
    chk(32'(d.file_addr), 32'(w[12:0]));
    chk(32'(d.to_default_working_reg), 32'h1);
    one(24'h6c0035);
    chk(32'({d.bit_in_file, d.bit_indirect, d.bit_pos}), 32'h35);
    one(24'h856ab0);
    chk(32'({d.lit_has_dest, d.literal}), 32'(w[14:4]));
    one(24'hc3b6e4);
    chk(32'({d.acc_b, d.mul_sel}), 32'(w[15:12]));
    chk(32'({d.x_pf_op, d.x_pf_dst, d.y_pf_op, d.y_pf_dst}), 32'(w[11:4]));
    chk(32'(d.acc_wb), 32'(w[3:2]));
    one(24'he54a7c);
    chk(32'({d.shift_from_reg, d.shift_lit}), 32'({w[14], w[7:4]}));
    chk(32'(d.acc_b), 32'(w[15]));
    chk(32'({d.src_mode, d.shift_count_reg}), 32'(w[6:0]));
    one(24'h031234);
    chk(32'(d.tbl_mode), 32'h4);
    chk(32'(d.prog_addr), 32'h001234);
  endtask : t_forms
  // Pair sent back to back or with one idle cycle between, one combined result
  task automatic t_pair(input logic [7:0] opc, input logic [23:0] w2, input logic fault, input logic gap);
    w = {opc, 16'h9c35};
    iwd_fetch_model_i.put(w);
    // Optional idle cycle between the two halves
    if (gap) begin
      iwd_fetch_model_i.idle();
    end
    iwd_fetch_model_i.put(w2);
    chk(32'(dw_pending), 32'h1);
    chk(32'(dec_valid), 32'h0);
    iwd_fetch_model_i.idle();
    chk(32'(dec_valid), 32'h1);
    chk(32'({d.is_double, d.opcode}), 32'({1'b1, opc}));
    chk(32'(d.prog_addr), 32'({w2[6:0], w[15:0]}));
    chk(32'(dw_pending), 32'h0);
    chk(32'(dw_fault), 32'(fault));
  endtask : t_pair
  // Flush drops a held first word; a lone zero-top word is a no-op
  task automatic t_flush();
    iwd_fetch_model_i.put(24'h045555);
    iwd_fetch_model_i.put(24'h2a0000);
    fetch_flush = 1'b1;
    iwd_fetch_model_i.idle();
    fetch_flush = 1'b0;
    chk(32'({dw_pending, dec_valid}), 32'h0);
    one(24'h00beef);
    chk(32'({d.is_nop, dw_fault}), 32'h2);
  endtask : t_flush
  // Reset in mid-pair forgets the held first word
  task automatic t_reset();
    iwd_fetch_model_i.put(24'h065555);
    iwd_fetch_model_i.idle();
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    chk(32'({dw_pending, dec_valid, dw_fault}), 32'h0);
    one(24'h2a0f0f);
  endtask : t_reset
  // =====================================
  // Main sequence
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    fetch_flush = 1'b0;
    w = 24'h000000;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk(32'({dw_pending, dec_valid, dw_fault}), 32'h0);
    t_forms();
    t_pair(8'h02, 24'h00004b, 1'b0, 1'b0);
    t_pair(8'h04, 24'h000035, 1'b0, 1'b1);
    t_pair(8'h06, 24'h0a1234, 1'b1, 1'b0);
    t_flush();
    t_reset();
    stop_test();
  end
  // Hang guard: a stuck run counts as a mismatch
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    stop_test();
  end
endmodule : iwd_decoder_tb_top
